// file: logic/mmel_regs.vh
// Constants for the monitor mode entry and single-wire host link block.
`ifndef MMEL_REGS_VH
`define MMEL_REGS_VH

`define MMEL_REG_CTRL 4'h0
`define MMEL_REG_MODE 4'h1
`define MMEL_REG_TXDATA 4'h4
`define MMEL_REG_RXDATA 4'h8
`define MMEL_REG_STATUS 4'hC
`define MMEL_CTRL_BRK_BIT 0

`define MMEL_BIT_EXT 9'h100
`define MMEL_BIT_INT 9'h14F
`define MMEL_FRAME_BITS 4'hA
`define MMEL_SEC_BYTES 4'h8

`define MMEL_ERASED 8'hFF
`define MMEL_PAGE_USER 8'hFF
`define MMEL_PAGE_MON 8'hFE
`define MMEL_VEC_RST_HI 16'hFFFE
`define MMEL_VEC_RST_LO 16'hFFFF
`define MMEL_VEC_SWI_HI 16'hFFFC

`endif

// file: logic/mmel_rx.v
// Serial receiver for the single-wire host link, with break detection.
`include "mmel_regs.vh"

module mmel_rx (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire line_i,
    input wire [8:0] period_i,
    output reg [7:0] data_o,
    output reg data_vld_o,
    output reg brk_o
);
    localparam S_IDLE = 2'b00;
    localparam S_BITS = 2'b01;
    localparam S_HOLD = 2'b10;

    reg [1:0] state_q;
    reg [8:0] cnt_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;

    always @(posedge clk_sys_i) begin
        data_vld_o <= 1'b0;
        brk_o <= 1'b0;
        if (!resetn_i) begin
            state_q <= S_IDLE;
            cnt_q <= 9'h000;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            data_o <= 8'h00;
        end else begin
            case (state_q)
                S_IDLE: begin
                    // Sampling starts half a bit in, so each bit is read mid-cell.
                    if (!line_i) begin
                        state_q <= S_BITS;
                        cnt_q <= {1'b0, period_i[8:1]};
                        bit_q <= 4'h0;
                    end
                end
                S_BITS: begin
                    if (cnt_q != 9'h000) begin
                        cnt_q <= cnt_q - 9'h001;
                    end else begin
                        cnt_q <= period_i - 9'h001;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h0) begin
                            if (line_i) begin
                                state_q <= S_IDLE;
                            end
                        end else if (bit_q < (`MMEL_FRAME_BITS - 4'h1)) begin
                            sh_q <= {line_i, sh_q[7:1]};
                        end else if (line_i) begin
                            data_o <= sh_q;
                            data_vld_o <= 1'b1;
                            state_q <= S_IDLE;
                        end else begin
                            // A low stop cell with all-zero data is a break.
                            brk_o <= (sh_q == 8'h00);
                            state_q <= S_HOLD;
                        end
                    end
                end
                S_HOLD: begin
                    if (line_i) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// file: logic/mmel_tx.v
// Open-drain serial transmitter for bytes and break characters.
`include "mmel_regs.vh"

module mmel_tx (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire start_i,
    input wire brk_i,
    input wire [7:0] data_i,
    input wire [8:0] period_i,
    output reg busy_o,
    output reg drive_low_o
);
    reg [9:0] sh_q;
    reg [3:0] n_q;
    reg [8:0] cnt_q;

    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sh_q <= 10'h000;
            n_q <= 4'h0;
            cnt_q <= 9'h000;
            busy_o <= 1'b0;
            drive_low_o <= 1'b0;
        end else if (!busy_o) begin
            drive_low_o <= 1'b0;
            if (start_i) begin
                sh_q <= brk_i ? 10'h000 : {1'b1, data_i, 1'b0};
                n_q <= `MMEL_FRAME_BITS;
                cnt_q <= period_i - 9'h001;
                busy_o <= 1'b1;
                drive_low_o <= 1'b1;
            end
        end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
        end else if (n_q == 4'h1) begin
            busy_o <= 1'b0;
            drive_low_o <= 1'b0;
        end else begin
            sh_q <= {1'b0, sh_q[9:1]};
            n_q <= n_q - 4'h1;
            cnt_q <= period_i - 9'h001;
            // Ones are sent by letting go of the line, never by driving it.
            drive_low_o <= ~sh_q[1];
        end
    end
endmodule

// file: logic/mmel_top.v
// Monitor mode entry, pin assignment, vector remap and host link control.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`include "mmel_regs.vh"

module mmel_top (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire int_rst_n_i,
    input wire test_high_voltage_i,
    input wire irq_level_i,
    input wire mode_select_pin_a_i,
    input wire mode_select_pin_b_i,
    input wire serial_comm_pin_i,
    output reg serial_comm_pin_o,
    output wire serial_comm_pin_oe_o,
    input wire cfg_reset_pin_en_i,
    input wire cfg_clock_pin_en_i,
    input wire interrupt_pin_enable_i,
    input wire cpu_rd_i,
    input wire [15:0] cpu_addr_i,
    input wire [7:0] cpu_data_i,
    output reg [15:0] fetch_addr_o,
    output reg extra_reset_o,
    output reg monitor_mode_o,
    output reg forced_mode_o,
    output reg internal_clock_sel_o,
    output reg watchdog_timer_disable_o,
    output reg shared_reset_pin_func_o,
    output reg oscillator_input_func_o,
    output reg serial_port_func_o,
    output reg branch_pin_enable_o,
    output reg port_bit2_o,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output reg [7:0] reg_rdata_o
);
    localparam M_USER = 2'b00;
    localparam M_SEC = 2'b01;
    localparam M_CMD = 2'b10;

    localparam NPIN = 5;
    // Reset leaves every pin at its idle level: high voltage off, interrupt and serial pins
    // pulled up. The mode taken when power-on reset ends therefore sees no high voltage.
    // It is the internal reset that follows which latches a real monitor entry.
    localparam [NPIN-1:0] PIN_IDLE = 5'h12;
    localparam [15:0] VEC_SWI = `MMEL_VEC_SWI_HI;

    // Vector cells of the user page that move to the monitor page.
    function is_vec;
        input [15:0] a;
        begin
            is_vec = (a[15:8] == `MMEL_PAGE_USER) && (a[7:2] == VEC_SWI[7:2]);
        end
    endfunction

    // Every pin input passes two flip-flops before any logic reads it.
    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] pin_m_q;
    reg [NPIN-1:0] pin_s_q;
    assign pin_raw = {serial_comm_pin_i, mode_select_pin_b_i, mode_select_pin_a_i,
                      irq_level_i, test_high_voltage_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_sync
            always @(posedge clk_sys_i) begin
                if (!resetn_i) begin
                    pin_m_q[g] <= PIN_IDLE[g];
                    pin_s_q[g] <= PIN_IDLE[g];
                end else begin
                    pin_m_q[g] <= pin_raw[g];
                    pin_s_q[g] <= pin_m_q[g];
                end
            end
        end
    endgenerate

    wire hv_s;
    wire irq_s;
    wire msel_a_s;
    wire msel_b_s;
    wire ser_s;
    assign hv_s = pin_s_q[0];
    assign irq_s = pin_s_q[1];
    assign msel_a_s = pin_s_q[2];
    assign msel_b_s = pin_s_q[3];
    assign ser_s = pin_s_q[4];

    // Mode state.
    reg int_rst_n_q;
    reg blank_hi_q;
    reg blank_q;
    reg mon_q;
    reg forced_q;
    reg intclk_q;
    reg hv_prev_q;
    reg hv_lost_q;
    reg [1:0] msel_q;
    reg [2:0] snap_q;
    reg sec_done_q;
    wire rst_rise;
    wire normal;
    assign rst_rise = int_rst_n_i & ~int_rst_n_q;
    assign normal = mon_q & ~forced_q;

    always @(posedge clk_sys_i) begin
        extra_reset_o <= 1'b0;
        if (!resetn_i) begin
            // A power-on reset is the only way out of a blank-vector entry.
            int_rst_n_q <= 1'b0;
            blank_hi_q <= 1'b0;
            blank_q <= 1'b0;
            mon_q <= 1'b0;
            forced_q <= 1'b0;
            intclk_q <= 1'b0;
            hv_prev_q <= 1'b0;
            hv_lost_q <= 1'b0;
            msel_q <= 2'b00;
            snap_q <= 3'b000;
        end else begin
            int_rst_n_q <= int_rst_n_i;
            hv_prev_q <= hv_s;
            if (rst_rise) begin
                // The blank flag survives other resets, so entry repeats.
                mon_q <= hv_s | blank_q;
                forced_q <= blank_q & ~hv_s;
                intclk_q <= blank_q & ~hv_s & ~irq_s;
                msel_q <= (blank_q & ~hv_s) ? 2'b00 : {msel_b_s, msel_a_s};
                hv_lost_q <= 1'b0;
            end else if (normal && hv_prev_q && !hv_s && !hv_lost_q) begin
                hv_lost_q <= 1'b1;
                snap_q <= {interrupt_pin_enable_i, cfg_clock_pin_en_i,
                           cfg_reset_pin_en_i};
            end
            // Watch the user reset vector fetches for an erased pair.
            if (!mon_q && cpu_rd_i && int_rst_n_i) begin
                if (cpu_addr_i == `MMEL_VEC_RST_HI) begin
                    blank_hi_q <= (cpu_data_i == `MMEL_ERASED);
                end else if (cpu_addr_i == `MMEL_VEC_RST_LO) begin
                    blank_hi_q <= 1'b0;
                    if (blank_hi_q && cpu_data_i == `MMEL_ERASED && !blank_q) begin
                        blank_q <= 1'b1;
                        extra_reset_o <= 1'b1;
                    end
                end
            end
        end
    end

    // Pin functions, watchdog and branch sampling, all registered.
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            monitor_mode_o <= 1'b0;
            forced_mode_o <= 1'b0;
            internal_clock_sel_o <= 1'b0;
            watchdog_timer_disable_o <= 1'b0;
            shared_reset_pin_func_o <= 1'b0;
            oscillator_input_func_o <= 1'b0;
            serial_port_func_o <= 1'b0;
            branch_pin_enable_o <= 1'b0;
            port_bit2_o <= 1'b0;
            fetch_addr_o <= 16'h0000;
            serial_comm_pin_o <= 1'b0;
        end else begin
            monitor_mode_o <= mon_q;
            forced_mode_o <= forced_q;
            internal_clock_sel_o <= intclk_q;
            serial_comm_pin_o <= 1'b0;
            watchdog_timer_disable_o <= forced_q | (normal & hv_s);
            serial_port_func_o <= mon_q;
            if (normal && !hv_lost_q) begin
                shared_reset_pin_func_o <= 1'b1;
                oscillator_input_func_o <= 1'b1;
            end else if (normal) begin
                shared_reset_pin_func_o <= snap_q[0];
                oscillator_input_func_o <= snap_q[1];
            end else if (forced_q) begin
                shared_reset_pin_func_o <= 1'b0;
                oscillator_input_func_o <= ~intclk_q;
            end else begin
                shared_reset_pin_func_o <= cfg_reset_pin_en_i;
                oscillator_input_func_o <= cfg_clock_pin_en_i;
            end
            // After the high voltage goes, the enable bit decides sampling.
            if (normal && hv_lost_q) begin
                branch_pin_enable_o <= interrupt_pin_enable_i;
            end else if (mon_q) begin
                branch_pin_enable_o <= 1'b1;
            end else begin
                branch_pin_enable_o <= interrupt_pin_enable_i;
            end
            port_bit2_o <= mon_q ? 1'b0 : irq_s;
            if (mon_q && is_vec(cpu_addr_i)) begin
                fetch_addr_o <= {`MMEL_PAGE_MON, cpu_addr_i[7:0]};
            end else begin
                fetch_addr_o <= cpu_addr_i;
            end
        end
    end

    // Host link.
    wire [8:0] period;
    assign period = intclk_q ? `MMEL_BIT_INT : `MMEL_BIT_EXT;

    wire tx_busy;
    wire [7:0] rx_data;
    wire rx_vld;
    wire rx_brk;
    wire rx_line;
    // The receiver is blind while we drive, so our own echo is not taken.
    assign rx_line = ser_s | tx_busy;

    reg [1:0] state_q;
    reg [3:0] sec_cnt_q;
    reg pend_q;
    reg pend_brk_q;
    reg [7:0] pend_data_q;
    reg [9:0] dly_q;
    reg sec_brk_q;
    reg sw_brk_q;
    reg [7:0] sw_data_q;
    reg sw_tx_q;
    reg [7:0] rxbuf_q;
    reg rxbuf_vld_q;

    reg tx_start;
    reg tx_brk;
    reg [7:0] tx_data;

    always @* begin
        tx_start = 1'b0;
        tx_brk = 1'b0;
        tx_data = 8'h00;
        if (!tx_busy) begin
            if (pend_q && dly_q == 10'h000) begin
                tx_start = 1'b1;
                tx_brk = pend_brk_q;
                tx_data = pend_data_q;
            end else if (!pend_q && sec_brk_q) begin
                tx_start = 1'b1;
                tx_brk = 1'b1;
            end else if (!pend_q && sw_brk_q) begin
                tx_start = 1'b1;
                tx_brk = 1'b1;
            end else if (!pend_q && sw_tx_q) begin
                tx_start = 1'b1;
                tx_data = sw_data_q;
            end
        end
    end

    wire wr_tx;
    wire wr_ctrl;
    wire rd_rx;
    assign wr_tx = reg_we_i && reg_addr_i == `MMEL_REG_TXDATA;
    assign wr_ctrl = reg_we_i && reg_addr_i == `MMEL_REG_CTRL;
    assign rd_rx = reg_re_i && reg_addr_i == `MMEL_REG_RXDATA;

    always @(posedge clk_sys_i) begin
        if (!resetn_i || !int_rst_n_i) begin
            state_q <= M_USER;
            sec_cnt_q <= 4'h0;
            pend_q <= 1'b0;
            pend_brk_q <= 1'b0;
            pend_data_q <= 8'h00;
            dly_q <= 10'h000;
            sec_brk_q <= 1'b0;
            sw_brk_q <= 1'b0;
            sw_tx_q <= 1'b0;
            sw_data_q <= 8'h00;
        end else begin
            if (pend_q && dly_q != 10'h000) begin
                dly_q <= dly_q - 10'h001;
            end
            if (tx_start) begin
                if (pend_q && dly_q == 10'h000) begin
                    pend_q <= 1'b0;
                end else if (sec_brk_q) begin
                    sec_brk_q <= 1'b0;
                end else if (sw_brk_q) begin
                    sw_brk_q <= 1'b0;
                end else begin
                    sw_tx_q <= 1'b0;
                end
            end
            // Software requests are refused while sending or while an echo or software send is queued.
            if (state_q == M_CMD && !tx_busy && !pend_q && !sw_tx_q && !sw_brk_q) begin
                if (wr_tx) begin
                    sw_tx_q <= 1'b1;
                    sw_data_q <= reg_wdata_i;
                end else if (wr_ctrl && reg_wdata_i[`MMEL_CTRL_BRK_BIT]) begin
                    sw_brk_q <= 1'b1;
                end
            end
            if ((rx_vld || rx_brk) && state_q != M_USER) begin
                pend_q <= 1'b1;
                pend_brk_q <= rx_brk;
                pend_data_q <= rx_data;
                dly_q <= {period, 1'b0};
            end
            case (state_q)
                M_USER: begin
                    if (mon_q) begin
                        state_q <= sec_done_q ? M_CMD : M_SEC;
                        sec_cnt_q <= 4'h0;
                    end
                end
                M_SEC: begin
                    if (rx_vld) begin
                        sec_cnt_q <= sec_cnt_q + 4'h1;
                    end
                    if (sec_cnt_q == `MMEL_SEC_BYTES) begin
                        sec_brk_q <= 1'b1;
                        state_q <= M_CMD;
                    end
                end
                M_CMD: begin
                    if (!mon_q) begin
                        state_q <= M_USER;
                    end
                end
                default: begin
                    state_q <= M_USER;
                end
            endcase
        end
    end

    // Security entry is remembered until power-on.
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            sec_done_q <= 1'b0;
        end else if (state_q == M_SEC && sec_cnt_q == `MMEL_SEC_BYTES) begin
            sec_done_q <= 1'b1;
        end
    end

    // Received byte for software; a new byte wins over a read clear.
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rxbuf_q <= 8'h00;
            rxbuf_vld_q <= 1'b0;
        end else if (rx_vld) begin
            rxbuf_q <= rx_data;
            rxbuf_vld_q <= 1'b1;
        end else if (rd_rx) begin
            rxbuf_vld_q <= 1'b0;
        end
    end

    // Register read port, data valid only in the cycle after the strobe.
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                `MMEL_REG_STATUS: begin
                    reg_rdata_o <= {blank_q, sec_done_q, rxbuf_vld_q, tx_busy,
                                    hv_lost_q, intclk_q, forced_q, mon_q};
                end
                `MMEL_REG_MODE: begin
                    reg_rdata_o <= {1'b0, state_q, snap_q, msel_q};
                end
                `MMEL_REG_RXDATA: begin
                    reg_rdata_o <= rxbuf_q;
                end
                `MMEL_REG_TXDATA: begin
                    reg_rdata_o <= sw_data_q;
                end
                default: begin
                    reg_rdata_o <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    mmel_rx u_rx (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .line_i(rx_line),
        .period_i(period),
        .data_o(rx_data),
        .data_vld_o(rx_vld),
        .brk_o(rx_brk)
    );

    mmel_tx u_tx (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(tx_start),
        .brk_i(tx_brk),
        .data_i(tx_data),
        .period_i(period),
        .busy_o(tx_busy),
        .drive_low_o(serial_comm_pin_oe_o)
    );
endmodule

// file: verif/mmel_properties.sv
// Checker of mode, vector and serial line relations seen at the top ports.
module mmel_checker (
    input wire clk_sys_i,
    input wire resetn_i,
    input wire int_rst_n_i,
    input wire [15:0] cpu_addr_i,
    input wire serial_comm_pin_o,
    input wire serial_comm_pin_oe_o,
    input wire [15:0] fetch_addr_o,
    input wire extra_reset_o,
    input wire monitor_mode_o,
    input wire forced_mode_o,
    input wire internal_clock_sel_o,
    input wire watchdog_timer_disable_o,
    input wire branch_pin_enable_o,
    input wire port_bit2_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    logic [11:0] run_q;
    // Length of the current low stretch; with the external clock a stretch must be whole bit times.
    always @(posedge clk_sys_i) begin
        if (!resetn_i || !serial_comm_pin_oe_o) begin
            run_q <= 12'h000;
        end else begin
            run_q <= run_q + 12'h001;
        end
    end
    a_bit_time: assert property ($fell(serial_comm_pin_oe_o) && !internal_clock_sel_o
        |-> run_q[7:0] == 8'h00 && run_q <= 12'hA00) else $error("low stretch not whole bits");
    a_drive_low: assert property (serial_comm_pin_oe_o |-> !serial_comm_pin_o)
        else $error("serial pin driven high");
    a_port_bit2: assert property (monitor_mode_o |-> !port_bit2_o)
        else $error("port bit 2 not zero in monitor mode");
    a_branch_on: assert property (forced_mode_o |-> branch_pin_enable_o)
        else $error("branch pin sampling off in forced mode");
    a_wdog_forced: assert property (forced_mode_o |-> watchdog_timer_disable_o)
        else $error("watchdog running in forced mode");
    a_forced_mon: assert property (forced_mode_o |-> monitor_mode_o)
        else $error("forced mode without monitor mode");
    a_vec_remap: assert property (monitor_mode_o && cpu_addr_i[15:2] == 14'h3FFF
        |=> fetch_addr_o == {8'hFE, $past(cpu_addr_i[7:0])}) else $error("vector not remapped");
    a_pulse_one: assert property (extra_reset_o |=> !extra_reset_o)
        else $error("extra reset pulse too long");
    a_forced_sticky: assert property (forced_mode_o && !int_rst_n_i |=> forced_mode_o)
        else $error("forced mode left on internal reset");
    c_extra: cover property (extra_reset_o);
    c_break: cover property ($fell(serial_comm_pin_oe_o) && run_q == 12'hA00);
    c_sticky: cover property (forced_mode_o && !int_rst_n_i);
endmodule

bind mmel_top mmel_checker u_chk (.*);

// file: verif/mmel_host.sv
// Host side of the single-wire link: frame sender and frame receiver.
module mmel_host_model #(
    parameter int BIT = 256
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic drive_low_o,
    output logic [8:0] rx_word_o,
    output logic rx_vld_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bit 8 asks for a break; the host only pulls the line low or lets it go.
    task automatic send(input logic [8:0] w);
        logic [9:0] f;
        f = w[8] ? 10'h000 : {1'b1, w[7:0], 1'b0};
        @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            drive_low_o <= !f[i];
            repeat (BIT) @(posedge clk_i);
        end
        drive_low_o <= 1'b0;
    endtask
    // Own frames are not received: a start counts only on a low the host is not driving.
    initial begin
        logic [8:0] w;
        drive_low_o = 1'b0;
        rx_word_o = 9'h000;
        rx_vld_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (!line_i && !drive_low_o) begin
                repeat (BIT / 2) @(posedge clk_i);
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT) @(posedge clk_i);
                    w[i] = line_i;
                end
                rx_word_o <= w[8] ? {1'b0, w[7:0]} : (w[7:0] == 8'h00 ? 9'h100 : 9'h1FF);
                rx_vld_o <= 1'b1;
                @(posedge clk_i);
                rx_vld_o <= 1'b0;
                while (!line_i) @(posedge clk_i);
            end
        end
    end
endmodule

// file: verif/mmel_top_tb_top.sv
// Self-checking bench: forced entry, host link traffic, registers and normal entry.
module mmel_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, int_rst_n_i = 1'b1, test_high_voltage_i = 1'b0;
    logic irq_level_i = 1'b1, mode_select_pin_a_i = 1'b0, mode_select_pin_b_i = 1'b0;
    logic cfg_reset_pin_en_i = 1'b0, cfg_clock_pin_en_i = 1'b0, interrupt_pin_enable_i = 1'b0;
    logic cpu_rd_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic [15:0] cpu_addr_i = 16'h0000;
    logic [7:0] cpu_data_i = 8'h00, reg_wdata_i = 8'h00, b, d;
    logic [3:0] reg_addr_i = 4'h0;
    wire [15:0] fetch_addr_o;
    wire [7:0] reg_rdata_o;
    wire [8:0] rx_word;
    wire serial_comm_pin_i, serial_comm_pin_o, serial_comm_pin_oe_o, extra_reset_o, rx_vld;
    wire monitor_mode_o, forced_mode_o, internal_clock_sel_o, watchdog_timer_disable_o, host_low;
    wire shared_reset_pin_func_o, oscillator_input_func_o, serial_port_func_o;
    wire branch_pin_enable_o, port_bit2_o;
    int fail_count = 0, compares = 0, cyc = 0;
    logic [8:0] exp_q[$];
    // The line has a pull-up: it is high unless one side pulls it low.
    assign serial_comm_pin_i = !host_low && !(serial_comm_pin_oe_o && !serial_comm_pin_o);
    mmel_top dut (.*);
    mmel_host_model host (.clk_i(clk_sys_i), .line_i(serial_comm_pin_i),
        .drive_low_o(host_low), .rx_word_o(rx_word), .rx_vld_o(rx_vld));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_sys_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_re_i <= 1'b0;
        @(negedge clk_sys_i);
        v = reg_rdata_o;
    endtask
    task automatic fetch(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        cpu_rd_i <= 1'b1;
        cpu_addr_i <= a;
        cpu_data_i <= v;
        @(posedge clk_sys_i);
        cpu_rd_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    // Waits until every expected frame has been seen by the host.
    task automatic drain;
        for (int n = 0; n < 12000 && exp_q.size() > 0; n++) @(posedge clk_sys_i);
        chk(16'(exp_q.size()), 16'h0000);
        // The device's stop bit and its receiver's false start must pass before the next send.
        tick(400);
    endtask
    task automatic int_reset;
        @(posedge clk_sys_i);
        int_rst_n_i <= 1'b0;
        tick(4);
        int_rst_n_i <= 1'b1;
        tick(6);
        @(negedge clk_sys_i);
    endtask
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (rx_vld) begin
            if (exp_q.size() == 0) chk({7'h00, rx_word}, 16'hFFFF);
            else chk({7'h00, rx_word}, {7'h00, exp_q.pop_front()});
        end
        if (cyc == 90000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        b = $urandom(53312);
        {mode_select_pin_a_i, cfg_reset_pin_en_i, cfg_clock_pin_en_i} <= b[2:0];
        interrupt_pin_enable_i <= b[3];
        tick(6);
        chk({15'h0000, serial_comm_pin_oe_o}, 16'h0000);
        resetn_i <= 1'b1;
        tick(4);
        fetch(16'hFFFE, 8'hFF);
        chk(fetch_addr_o, 16'hFFFE);
        fetch(16'hFFFF, 8'hFF);
        for (int n = 0; n < 8 && extra_reset_o !== 1'b1; n++) @(negedge clk_sys_i);
        chk({15'h0000, extra_reset_o}, 16'h0001);
        mode_select_pin_b_i <= b[4];
        int_reset;
        chk({13'h0000, forced_mode_o, monitor_mode_o, watchdog_timer_disable_o}, 16'h0007);
        chk({10'h000, serial_port_func_o, oscillator_input_func_o, shared_reset_pin_func_o,
            internal_clock_sel_o, port_bit2_o, branch_pin_enable_o}, 16'h0031);
        fetch(16'hFFFC, 8'h00);
        chk(fetch_addr_o, 16'hFEFC);
        for (int i = 0; i < 8; i++) begin
            b = $urandom;
            exp_q.push_back({1'b0, b});
            if (i == 7) exp_q.push_back(9'h100);
            host.send({1'b0, b});
            drain;
        end
        rd(4'hC, d);
        chk({8'h00, d & 8'hC7}, 16'h00C3);
        rd(4'h8, d);
        chk({8'h00, d}, {8'h00, b});
        rd(4'h2, d);
        chk({8'h00, d}, 16'h0000);
        exp_q.push_back(9'h100);
        host.send(9'h100);
        drain;
        b = $urandom;
        exp_q.push_back({1'b0, b});
        wr(4'h4, b);
        drain;
        exp_q.push_back(9'h100);
        wr(4'h0, 8'h01);
        drain;
        int_reset;
        chk({15'h0000, forced_mode_o}, 16'h0001);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        test_high_voltage_i <= 1'b1;
        tick(6);
        resetn_i <= 1'b1;
        int_reset;
        chk({11'h000, forced_mode_o, monitor_mode_o, watchdog_timer_disable_o,
            shared_reset_pin_func_o, oscillator_input_func_o}, 16'h000F);
        @(posedge clk_sys_i);
        test_high_voltage_i <= 1'b0;
        tick(6);
        @(negedge clk_sys_i);
        chk({15'h0000, shared_reset_pin_func_o}, {15'h0000, cfg_reset_pin_en_i});
        chk({15'h0000, branch_pin_enable_o}, {15'h0000, interrupt_pin_enable_i});
        chk({15'h0000, watchdog_timer_disable_o}, 16'h0000);
        end_of_test;
    end
endmodule
